// >>> common/cache_defs.svh
// Purpose: constants of the paged write-back cache
// Assumes: byte-addressed 32-bit word accesses, 32-byte lines
`ifndef CACHE_DEFS_SVH
`define CACHE_DEFS_SVH

`define CACHE_WAYS 2
`define CACHE_SETS 128
`define LINE_WORDS 8
`define WORD_LSB 2
`define WORD_W 3
`define IDX_LSB 5
`define IDX_W 7
`define TAG_LSB 12
`define TAG_W 13
`define PAGE_COUNT 16
`define PAGE_W 4
`define PAGE_LSB 21
`define VBASE_W 11
`define PHYS_TOP_W 7

`endif

// >>> common/cache_pkg.sv
// Purpose: types of the paged write-back cache
// Assumes: nothing beyond the defs header
// Notes: mode bit 0 enables data, bit 1 instructions
package cache_pkg;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_DATA = 2'b01,
        MODE_INSTR = 2'b10,
        MODE_UNIFIED = 2'b11
    } cache_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_SINGLE = 3'b010,
        ST_WBACK = 3'b011,
        ST_FILL = 3'b100,
        ST_DONE = 3'b101
    } state_t;

endpackage

// >>> testbench/bus_mem_model.sv
// Purpose: memory on the far side of the cache's system bus port
// Assumes: one beat at a time, ready raised after lat_i waiting cycles
// Notes: read data is inverted every cycle while no read beat is offered
`timescale 1ns/100ps
module bus_mem_model (
    input wire logic clk_i,
    input wire logic [31:0] lat_i,
    input wire logic bus_req_i,
    input wire logic bus_we_i,
    input wire logic [31:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    output logic [31:0] bus_rdata_o,
    output logic bus_ready_o
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] a_q, d_q, last_raddr, cnt;
    logic we_q;
    int rd_n, wr_n;

    function automatic logic [31:0] rd(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : {a[15:0], ~a[15:0]};
    endfunction

    initial begin
        bus_ready_o = 1'b0;
        bus_rdata_o = 32'h0;
        cnt = 32'h0;
        rd_n = 0;
        wr_n = 0;
        last_raddr = 32'h0;
    end

    // beat ends at the edge where ready was high, bus outputs held until then
    always @(posedge clk_i) begin
        #1;
        if (bus_ready_o) begin
            if (we_q) begin
                mem[a_q] = d_q;
                wr_n++;
            end else begin
                rd_n++;
                last_raddr = a_q;
            end
            bus_ready_o = 1'b0;
            cnt = 32'h0;
        end
        bus_rdata_o = ~bus_rdata_o;
        if (bus_req_i && cnt >= lat_i) begin
            a_q = bus_addr_i & 32'hFFFF_FFFC;
            we_q = bus_we_i;
            d_q = bus_wdata_i;
            if (!we_q) begin
                bus_rdata_o = rd(a_q);
            end
            bus_ready_o = 1'b1;
        end else if (bus_req_i) begin
            cnt++;
        end
    end
endmodule

// >>> testbench/paged_writeback_cache_test.sv
// Purpose: self-checking bench for the paged write-back cache
// Assumes: memory model answers beats, ce low only in the freeze scenario
// Notes: cycle counts measured from request to ready
`timescale 1ns/100ps
module paged_writeback_cache_test
    import cache_pkg::*;
;
    logic clk_i, arst_n_i, ce, cpu_req, cpu_we, cpu_instr, cpu_ready, bus_req, bus_we, bus_ready;
    cache_mode_t mode;
    logic [15:0] page_en;
    logic [175:0] vbase;
    logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, bus_addr, bus_wdata, bus_rdata, lat, q, r0, w0;
    int err_count, checks;

    paged_cache DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce), .cfg_mode_i(mode),
        .page_en_i(page_en), .page_vbase_i(vbase), .cpu_req_i(cpu_req), .cpu_we_i(cpu_we),
        .cpu_instr_i(cpu_instr), .cpu_addr_i(cpu_addr), .cpu_wdata_i(cpu_wdata),
        .cpu_rdata_o(cpu_rdata), .cpu_ready_o(cpu_ready), .bus_req_o(bus_req), .bus_we_o(bus_we),
        .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata), .bus_rdata_i(bus_rdata), .bus_ready_i(bus_ready));

    bus_mem_model mdl (.clk_i(clk_i), .lat_i(lat), .bus_req_i(bus_req), .bus_we_i(bus_we),
        .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata), .bus_ready_o(bus_ready));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask

    // one processor access, cycle count checked, read data left in q
    task automatic go(input logic we, input logic ins, input logic [31:0] a, input logic [31:0] d,
            input logic [31:0] ec);
        logic [31:0] cyc;
        cpu_we = we;
        cpu_instr = ins;
        cpu_addr = a;
        cpu_wdata = d;
        cpu_req = 1'b1;
        cyc = 32'h0;
        do begin
            @(posedge clk_i);
            #1;
            cyc++;
        end while (cpu_ready !== 1'b1 && cyc < 32'd300);
        if (cpu_ready !== 1'b1) begin
            err_count++;
            test_done();
        end
        q = cpu_rdata;
        cpu_req = 1'b0;
        chk("cycles", ec, cyc);
        @(posedge clk_i);
        #1;
    endtask

    task automatic snap();
        r0 = 32'(mdl.rd_n);
        w0 = 32'(mdl.wr_n);
    endtask

    task automatic deltas(input logic [31:0] er, input logic [31:0] ew);
        chk("bus reads", er, 32'(mdl.rd_n) - r0);
        chk("bus writes", ew, 32'(mdl.wr_n) - w0);
    endtask

    task automatic t_fill_hit();
        snap();
        go(1'b0, 1'b0, 32'h40, 32'h0, 32'd10);
        chk("fill data", 32'h0040_FFBF, q);
        deltas(32'd8, 32'd0);
        go(1'b0, 1'b1, 32'h44, 32'h0, 32'd1);
        chk("hit data", 32'h0044_FFBB, q);
        deltas(32'd8, 32'd0);
    endtask

    task automatic t_writes();
        snap();
        go(1'b1, 1'b0, 32'h44, 32'hCAFE_0001, 32'd1);
        go(1'b0, 1'b0, 32'h44, 32'h0, 32'd1);
        chk("write hit data", 32'hCAFE_0001, q);
        deltas(32'd0, 32'd0);
        go(1'b1, 1'b0, 32'h1044, 32'hBEEF_0002, 32'd3);
        chk("write miss addr", 32'h1044, mdl.a_q);
        deltas(32'd0, 32'd1);
        go(1'b0, 1'b0, 32'h1044, 32'h0, 32'd10);
        chk("write miss data", 32'hBEEF_0002, q);
    endtask

    task automatic t_evict();
        snap();
        go(1'b0, 1'b0, 32'h2040, 32'h0, 32'd18);
        deltas(32'd8, 32'd8);
        go(1'b0, 1'b0, 32'h1044, 32'h0, 32'd1);
        go(1'b0, 1'b0, 32'h44, 32'h0, 32'd10);
        chk("written back", 32'hCAFE_0001, q);
        deltas(32'd16, 32'd8);
        go(1'b0, 1'b0, 32'h1044, 32'h0, 32'd1);
        chk("other way kept", 32'hBEEF_0002, q);
    endtask

    // clock enable low: a pending hit must not be answered
    task automatic t_freeze();
        int n = 0;
        ce = 1'b0;
        cpu_we = 1'b0;
        cpu_instr = 1'b0;
        cpu_addr = 32'h1044;
        cpu_req = 1'b1;
        repeat (4) begin
            @(posedge clk_i);
            #1;
            if (cpu_ready !== 1'b0 || bus_req !== 1'b0) begin
                n++;
            end
        end
        chk("frozen answers", 32'h0, 32'(n));
        cpu_req = 1'b0;
        ce = 1'b1;
        @(posedge clk_i);
        #1;
        go(1'b0, 1'b0, 32'h1044, 32'h0, 32'd1);
        chk("thawed hit data", 32'hBEEF_0002, q);
    endtask

    task automatic t_modes();
        logic [31:0] a;
        for (int i = 0; i < 8; i++) begin
            mode = cache_mode_t'(i[2:1]);
            a = 32'h400 + 32'(i) * 32'h20;
            snap();
            go(1'b0, i[0], a, 32'h0, mode[i[0]] ? 32'd10 : 32'd3);
            deltas(mode[i[0]] ? 32'd8 : 32'd1, 32'd0);
            chk("mode data", {a[15:0], ~a[15:0]}, q);
        end
        mode = MODE_UNIFIED;
    endtask

    task automatic t_bypass();
        page_en = 16'h0000;
        lat = 32'd2;
        snap();
        go(1'b0, 1'b0, 32'h40, 32'h0, 32'd5);
        chk("bypass data", 32'h0040_FFBF, q);
        deltas(32'd1, 32'd0);
        lat = 32'd0;
    endtask

    task automatic t_page();
        page_en = 16'h0008;
        vbase[3*11+:11] = 11'h100;
        go(1'b0, 1'b0, 32'h2000_0104, 32'h0, 32'd10);
        chk("page data", 32'h0104_FEFB, q);
        chk("page line end", 32'h0060_011C, mdl.last_raddr);
        page_en = 16'h0000;
        go(1'b0, 1'b0, 32'h2000_0104, 32'h0, 32'd3);
        chk("unmapped addr", 32'h2000_0104, mdl.last_raddr);
    endtask

    initial begin
        arst_n_i = 1'b0;
        ce = 1'b1;
        cpu_req = 1'b0;
        cpu_we = 1'b0;
        cpu_instr = 1'b0;
        cpu_addr = 32'h0;
        cpu_wdata = 32'h0;
        mode = MODE_UNIFIED;
        page_en = 16'h0001;
        vbase = 176'h0;
        lat = 32'd0;
        err_count = 0;
        checks = 0;
        repeat (3) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        chk("ready after reset", 32'h0, 32'(cpu_ready));
        chk("bus req after reset", 32'h0, 32'(bus_req));
        t_fill_hit();
        t_writes();
        t_evict();
        t_freeze();
        t_modes();
        t_bypass();
        t_page();
        test_done();
    end
endmodule

// >>> verilog/page_match.sv
// Purpose: compares an address against one page's virtual base
// Assumes: base and address are the bits above the page offset
// Notes: a disabled page never matches
`timescale 1ns/100ps
module page_match #(
    parameter int BASE_W = 11
) (
    input wire logic en_i,
    input wire logic [BASE_W-1:0] vbase_i,
    input wire logic [BASE_W-1:0] vaddr_i,
    output logic hit_o
);
    assign hit_o = en_i && (vbase_i == vaddr_i);
endmodule

// >>> verilog/paged_cache.sv
// Purpose: 2-way write-back cache between processor and system bus
// Assumes: one request held until cpu_ready_o, word accesses only
// Notes: lowest enabled matching page wins
`timescale 1ns/100ps
`include "cache_defs.svh"
module paged_cache
    import cache_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire cache_mode_t cfg_mode_i,
    input wire logic [`PAGE_COUNT-1:0] page_en_i,
    input wire logic [`PAGE_COUNT*`VBASE_W-1:0] page_vbase_i,
    input wire logic cpu_req_i,
    input wire logic cpu_we_i,
    input wire logic cpu_instr_i,
    input wire logic [31:0] cpu_addr_i,
    input wire logic [31:0] cpu_wdata_i,
    output logic [31:0] cpu_rdata_o,
    output logic cpu_ready_o,
    output logic bus_req_o,
    output logic bus_we_o,
    output logic [31:0] bus_addr_o,
    output logic [31:0] bus_wdata_o,
    input wire logic [31:0] bus_rdata_i,
    input wire logic bus_ready_i
);
    localparam int LINES = `CACHE_SETS * `LINE_WORDS;

    state_t state_q;
    logic [31:0] cpu_rdata_q;
    logic cpu_ready_q;
    logic bus_req_q;
    logic bus_we_q;
    logic [31:0] bus_addr_q;
    logic [31:0] bus_wdata_q;
    logic [31:0] r_addr_q;
    logic r_we_q;
    logic [31:0] r_wdata_q;
    logic victim_q;
    logic [`WORD_W-1:0] cnt_q;

    logic [31:0] data_mem [`CACHE_WAYS][LINES];
    logic [`TAG_W-1:0] tag_mem [`CACHE_WAYS][`CACHE_SETS];
    logic [`CACHE_WAYS-1:0] valid_q [`CACHE_SETS];
    logic [`CACHE_WAYS-1:0] dirty_q [`CACHE_SETS];
    logic [`CACHE_SETS-1:0] lru_q;

    logic [`PAGE_COUNT-1:0] page_hit;
    logic pg_found;
    logic [`PAGE_W-1:0] pg_idx;
    logic [31:0] phys;
    logic type_ok;
    logic cacheable;
    logic [`IDX_W-1:0] idx;
    logic [`TAG_W-1:0] tag;
    logic [`WORD_W-1:0] wrd;
    logic hit0;
    logic hit1;
    logic hit;
    logic hit_way;
    logic take;
    logic [`IDX_W-1:0] r_idx;
    logic [`WORD_W-1:0] r_wrd;
    logic vic;

    // one comparator per page
    genvar g;
    generate
        for (g = 0; g < `PAGE_COUNT; g++) begin : g_page
            page_match #(
                .BASE_W(`VBASE_W)
            ) u_match (
                .en_i(page_en_i[g]),
                .vbase_i(page_vbase_i[g*`VBASE_W +: `VBASE_W]),
                .vaddr_i(cpu_addr_i[31:`PAGE_LSB]),
                .hit_o(page_hit[g])
            );
        end
    endgenerate

    always_comb begin
        pg_found = 1'b0;
        pg_idx = '0;
        for (int i = 0; i < `PAGE_COUNT; i++) begin
            if (page_hit[i] && !pg_found) begin
                pg_found = 1'b1;
                pg_idx = `PAGE_W'(i);
            end
        end
    end

    // page maps onto its 2 MB slot of the bottom 32 MB
    assign phys = pg_found ? {{`PHYS_TOP_W{1'b0}}, pg_idx, cpu_addr_i[`PAGE_LSB-1:0]} : cpu_addr_i;
    assign type_ok = cpu_instr_i ? cfg_mode_i[1] : cfg_mode_i[0];
    assign cacheable = pg_found && type_ok;
    assign idx = phys[`IDX_LSB +: `IDX_W];
    assign tag = phys[`TAG_LSB +: `TAG_W];
    assign wrd = phys[`WORD_LSB +: `WORD_W];
    assign hit0 = valid_q[idx][0] && (tag_mem[0][idx] == tag);
    assign hit1 = valid_q[idx][1] && (tag_mem[1][idx] == tag);
    assign hit = hit0 || hit1;
    assign hit_way = hit1;
    assign take = ce_i && (state_q == ST_IDLE) && cpu_req_i && !cpu_ready_q;
    assign r_idx = r_addr_q[`IDX_LSB +: `IDX_W];
    assign r_wrd = r_addr_q[`WORD_LSB +: `WORD_W];
    assign vic = lru_q[idx];

    // sequencing and bus master
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            bus_req_q <= 1'b0;
            bus_we_q <= 1'b0;
            bus_addr_q <= 32'h0000_0000;
            bus_wdata_q <= 32'h0000_0000;
            r_addr_q <= 32'h0000_0000;
            r_we_q <= 1'b0;
            r_wdata_q <= 32'h0000_0000;
            victim_q <= 1'b0;
            cnt_q <= '0;
        end else if (ce_i) begin
            unique case (state_q)
                ST_IDLE: begin
                    if (take) begin
                        r_addr_q <= phys;
                        r_we_q <= cpu_we_i;
                        r_wdata_q <= cpu_wdata_i;
                        cnt_q <= '0;
                        if (cacheable && hit) begin
                            state_q <= ST_IDLE;
                        end else if (cacheable && !cpu_we_i) begin
                            victim_q <= vic;
                            bus_req_q <= 1'b1;
                            if (valid_q[idx][vic] && dirty_q[idx][vic]) begin
                                state_q <= ST_WBACK;
                                bus_we_q <= 1'b1;
                                bus_addr_q <= {{`PHYS_TOP_W{1'b0}}, tag_mem[vic][idx], idx, 5'h00};
                                bus_wdata_q <= data_mem[vic][{idx, 3'h0}];
                            end else begin
                                state_q <= ST_FILL;
                                bus_we_q <= 1'b0;
                                bus_addr_q <= {phys[31:`IDX_LSB], 5'h00};
                            end
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    state_q <= ST_SINGLE;
                    bus_req_q <= 1'b1;
                    bus_we_q <= r_we_q;
                    bus_addr_q <= {r_addr_q[31:`WORD_LSB], 2'h0};
                    bus_wdata_q <= r_wdata_q;
                end
                ST_SINGLE: begin
                    if (bus_ready_i) begin
                        state_q <= ST_IDLE;
                        bus_req_q <= 1'b0;
                        bus_we_q <= 1'b0;
                    end
                end
                ST_WBACK: begin
                    if (bus_ready_i) begin
                        if (cnt_q == 3'h7) begin
                            state_q <= ST_FILL;
                            bus_we_q <= 1'b0;
                            bus_addr_q <= {r_addr_q[31:`IDX_LSB], 5'h00};
                            cnt_q <= '0;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                            bus_addr_q <= bus_addr_q + 32'h0000_0004;
                            bus_wdata_q <= data_mem[victim_q][{r_idx, cnt_q + 3'h1}];
                        end
                    end
                end
                ST_FILL: begin
                    if (bus_ready_i) begin
                        cnt_q <= cnt_q + 3'h1;
                        bus_addr_q <= bus_addr_q + 32'h0000_0004;
                        if (cnt_q == 3'h7) begin
                            state_q <= ST_DONE;
                            bus_req_q <= 1'b0;
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    bus_req_q <= 1'b0;
                end
            endcase
        end
    end

    // answers to the processor
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cpu_ready_q <= 1'b0;
            cpu_rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            cpu_ready_q <= 1'b0;
            if (take && cacheable && hit) begin
                cpu_ready_q <= 1'b1;
                if (!cpu_we_i) begin
                    cpu_rdata_q <= data_mem[hit_way][{idx, wrd}];
                end
            end else if (state_q == ST_SINGLE && bus_ready_i) begin
                cpu_ready_q <= 1'b1;
                if (!r_we_q) begin
                    cpu_rdata_q <= bus_rdata_i;
                end
            end else if (state_q == ST_DONE) begin
                cpu_ready_q <= 1'b1;
                cpu_rdata_q <= data_mem[victim_q][{r_idx, r_wrd}];
            end
        end
    end

    // line storage
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (take && cacheable && hit && cpu_we_i) begin
                data_mem[hit_way][{idx, wrd}] <= cpu_wdata_i;
            end
            if (state_q == ST_FILL && bus_ready_i) begin
                data_mem[victim_q][{r_idx, cnt_q}] <= bus_rdata_i;
                if (cnt_q == 3'h7) begin
                    tag_mem[victim_q][r_idx] <= r_addr_q[`TAG_LSB +: `TAG_W];
                end
            end
        end
    end

    // valid, dirty and recency bits
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int s = 0; s < `CACHE_SETS; s++) begin
                valid_q[s] <= 2'h0;
                dirty_q[s] <= 2'h0;
            end
            lru_q <= '0;
        end else if (ce_i) begin
            if (take && cacheable && hit) begin
                lru_q[idx] <= ~hit_way;
                if (cpu_we_i) begin
                    dirty_q[idx][hit_way] <= 1'b1;
                end
            end
            if (state_q == ST_FILL && bus_ready_i && cnt_q == 3'h7) begin
                valid_q[r_idx][victim_q] <= 1'b1;
                dirty_q[r_idx][victim_q] <= 1'b0;
                lru_q[r_idx] <= ~victim_q;
            end
        end
    end

    assign cpu_rdata_o = cpu_rdata_q;
    assign cpu_ready_o = cpu_ready_q;
    assign bus_req_o = bus_req_q;
    assign bus_we_o = bus_we_q;
    assign bus_addr_o = bus_addr_q;
    assign bus_wdata_o = bus_wdata_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    read_hit_zero_a: assert property (take && cacheable && hit && !cpu_we_i |=> cpu_ready_q)
        else $error("read hit not answered next cycle");
    write_hit_dirty_a: assert property (take && cacheable && hit && cpu_we_i |=> dirty_q[$past(idx)][$past(hit_way)])
        else $error("write hit did not mark line dirty");
    recency_flip_a: assert property (take && cacheable && hit |=> lru_q[$past(idx)] == !$past(hit_way))
        else $error("recency bit not moved off hit way");
    bypass_wait_a: assert property (take && !cacheable |=> state_q == ST_WAIT && !bus_req_q)
        else $error("bypass access lost its extra wait state");
    write_miss_direct_a: assert property (take && cacheable && !hit && cpu_we_i |=> state_q == ST_WAIT)
        else $error("write miss allocated a line");
    wback_writes_a: assert property (state_q == ST_WBACK |-> bus_req_q && bus_we_q)
        else $error("writeback not writing");
    fill_end_a: assert property (ce_i && state_q == ST_FILL && bus_ready_i && cnt_q == 3'h7 |=> state_q == ST_DONE)
        else $error("fill did not end after eighth word");
    fill_page_a: assert property (state_q == ST_FILL |-> bus_req_q && !bus_we_q && bus_addr_q[31:25] == 7'h00)
        else $error("fill outside cached pages");
    excluded_type_a: assert property (take && cpu_instr_i && cfg_mode_i == MODE_DATA |=> state_q == ST_WAIT)
        else $error("excluded access type was cached");

    read_hit_c: cover property (take && cacheable && hit && !cpu_we_i);
    wback_fill_c: cover property (state_q == ST_WBACK ##[1:40] state_q == ST_FILL);
    bypass_c: cover property (state_q == ST_SINGLE && bus_ready_i);
endmodule
